/* File: common/bsd_ctrl_pkg.sv */
// Package: constants and types for the bit-serial decoder control shell
package bsd_ctrl_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [15:0] ADDR_ERR_STATUS = 16'h4400;
	localparam logic [15:0] ADDR_ERR_COUNT  = 16'h4404;
	localparam logic [15:0] ADDR_STREAMER   = 16'h4000;
	localparam logic [15:0] ADDR_FLUSH_CTL  = 16'h4008;
	localparam logic [15:0] RST_ERR_STATUS  = 16'h0000;
	localparam logic [11:0] RST_ERR_COUNT   = 12'h000;
	localparam logic [11:0] CNT_MAX         = 12'hfff;
	localparam int          ERR_BITS        = 4;
	localparam int          BIT_DEC_ERR     = 0;
	localparam int          BIT_VLD_ERR     = 1;
	localparam int          BIT_MVP_ERR     = 2;
	localparam int          BIT_EARLY_ERR   = 3;
	localparam int          FLUSH_REQ_BIT   = 0;
	localparam int          STREAMER_BIT    = 0;
	// ---------------------------------------------------------------
	// Data path
	// ---------------------------------------------------------------
	localparam int          MEM_W           = 512;
	localparam int          PCM_BYTES       = 384;
	localparam logic [8:0]  PCM_BEATS       = 9'd6;
	localparam logic [7:0]  EPB_BYTE        = 8'h03;
	localparam logic [1:0]  CHROMA_MONO     = 2'h0;

	typedef struct packed {
		logic        pcm;
		logic [1:0]  chroma_fmt;
		logic [3:0]  cbp_luma;
		logic [1:0]  cbp_chroma;
		logic [1:0]  intra16_mode;
		logic        dc_flags;
	} mb_param_t;

	typedef struct packed {
		logic [3:0]  cbp_luma;
		logic [1:0]  cbp_chroma;
		logic        cb_present;
		logic        cr_present;
		logic        non_skipped;
		logic        dc_flags;
		logic [1:0]  intra16_mode;
	} mb_ctrl_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SLICE = 3'b001,
		ST_IFLSH = 3'b010,
		ST_XFLSH = 3'b011,
		ST_STORE = 3'b100
	} seq_state_t;
endpackage

/* File: src/bsd_ctrl.sv */
// Control and status shell of the bit-serial slice decoder
`timescale 1ns/10ps
module bsd_ctrl (
	input  wire logic                                sys_clk_i,
	input  wire logic                                srst_i,
	// Register port
	input  wire logic                                reg_wr_i,
	input  wire logic                                reg_rd_i,
	input  wire logic [15:0]                         reg_addr_i,
	input  wire logic [31:0]                         reg_wdata_i,
	output logic      [31:0]                         reg_rdata_o,
	output logic                                     reg_ack_o,
	// Slice command from the streamer
	input  wire logic                                slice_start_i,
	input  wire logic [bsd_ctrl_pkg::ERR_BITS-1:0]   err_enable_i,
	output logic                                     slice_busy_o,
	output logic                                     slice_done_o,
	// Unit error events
	input  wire logic [bsd_ctrl_pkg::ERR_BITS-1:0]   err_event_i,
	// Memory read side
	input  wire logic                                mem_valid_i,
	input  wire logic [bsd_ctrl_pkg::MEM_W-1:0]      mem_data_i,
	input  wire logic                                mem_last_i,
	output logic                                     mem_req_o,
	// Byte stream to parser core
	output logic                                     byte_valid_o,
	output logic      [7:0]                          byte_data_o,
	output logic                                     slice_end_o,
	// Macroblock parameters
	input  wire logic                                mb_valid_i,
	input  wire bsd_ctrl_pkg::mb_param_t             mb_param_i,
	output bsd_ctrl_pkg::mb_ctrl_t                   mb_ctrl_o,
	output logic                                     pcm_active_o,
	// Flush handshake and error interrupt
	input  wire logic                                input_done_i,
	input  wire logic                                parser_done_i,
	input  wire logic                                memif_done_i,
	output logic                                     flush_o,
	output logic                                     store_dword_o,
	output logic                                     irq_o
);
	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	bsd_ctrl_pkg::seq_state_t state_ff, nxt_state;
	logic                     flush_ff, nxt_flush;
	logic                     store_ff, nxt_store;
	logic                     xflush_req_ff, nxt_xflush_req;
	logic                     done_ff, nxt_done;
	logic                     busy_ff, nxt_busy;
	logic [bsd_ctrl_pkg::ERR_BITS-1:0] en_ff, nxt_en;
	logic                     all_done;
	logic                     wr_status, wr_count, wr_flush;

	assign all_done  = input_done_i & parser_done_i & memif_done_i;
	assign wr_status = reg_wr_i && reg_addr_i == bsd_ctrl_pkg::ADDR_ERR_STATUS;
	assign wr_count  = reg_wr_i && reg_addr_i == bsd_ctrl_pkg::ADDR_ERR_COUNT;
	assign wr_flush  = reg_wr_i && reg_addr_i == bsd_ctrl_pkg::ADDR_FLUSH_CTL;

	always_comb begin
		nxt_state      = state_ff;
		nxt_flush      = 1'b0;
		nxt_store      = 1'b0;
		nxt_done       = 1'b0;
		nxt_en         = en_ff;
		nxt_xflush_req = xflush_req_ff;
		if (wr_flush && reg_wdata_i[bsd_ctrl_pkg::FLUSH_REQ_BIT]) begin
			nxt_xflush_req = 1'b1;
		end
		case (state_ff)
			bsd_ctrl_pkg::ST_IDLE: begin
				if (slice_start_i) begin
					nxt_state = bsd_ctrl_pkg::ST_SLICE;
					nxt_en    = err_enable_i;
				end else if (xflush_req_ff) begin
					nxt_state      = bsd_ctrl_pkg::ST_XFLSH;
					nxt_xflush_req = 1'b0;
				end
			end
			bsd_ctrl_pkg::ST_SLICE: begin
				// New starts ignored until the sequencer is back in ST_IDLE after the flush
				if (slice_end_o) begin
					nxt_state = bsd_ctrl_pkg::ST_IFLSH;
				end
			end
			bsd_ctrl_pkg::ST_IFLSH: begin
				nxt_flush = 1'b1;
				if (all_done) begin
					nxt_state = bsd_ctrl_pkg::ST_IDLE;
					nxt_done  = 1'b1;
					nxt_flush = 1'b0;
				end
			end
			bsd_ctrl_pkg::ST_XFLSH: begin
				nxt_flush = 1'b1;
				if (all_done) begin
					nxt_state = bsd_ctrl_pkg::ST_STORE;
					nxt_flush = 1'b0;
				end
			end
			bsd_ctrl_pkg::ST_STORE: begin
				nxt_store = 1'b1;
				nxt_state = bsd_ctrl_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = bsd_ctrl_pkg::ST_IDLE;
			end
		endcase
		nxt_busy = nxt_state != bsd_ctrl_pkg::ST_IDLE;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_ff      <= bsd_ctrl_pkg::ST_IDLE;
			flush_ff      <= 1'b0;
			store_ff      <= 1'b0;
			done_ff       <= 1'b0;
			busy_ff       <= 1'b0;
			en_ff         <= '0;
			xflush_req_ff <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			flush_ff      <= nxt_flush;
			store_ff      <= nxt_store;
			done_ff       <= nxt_done;
			busy_ff       <= nxt_busy;
			en_ff         <= nxt_en;
			xflush_req_ff <= nxt_xflush_req;
		end
	end

	// ---------------------------------------------------------------
	// Input fetch: line unpacking and escape removal
	// ---------------------------------------------------------------
	logic [bsd_ctrl_pkg::MEM_W-1:0] line_ff, nxt_line;
	logic [6:0]                     idx_ff, nxt_idx;
	logic                           full_ff, nxt_full;
	logic                           last_ff, nxt_last;
	logic [1:0]                     zeros_ff, nxt_zeros;
	logic                           bvalid_ff, nxt_bvalid;
	logic [7:0]                     bdata_ff, nxt_bdata;
	logic                           end_ff, nxt_end;
	logic                           req_ff, nxt_req;
	logic [7:0]                     cur_byte;
	logic                           in_slice;

	assign in_slice = state_ff == bsd_ctrl_pkg::ST_SLICE;
	assign cur_byte = line_ff[{idx_ff[5:0], 3'b000} +: 8];

	always_comb begin
		nxt_line   = line_ff;
		nxt_idx    = idx_ff;
		nxt_full   = full_ff;
		nxt_last   = last_ff;
		nxt_zeros  = zeros_ff;
		nxt_bvalid = 1'b0;
		nxt_bdata  = bdata_ff;
		nxt_end    = 1'b0;
		nxt_req    = 1'b0;
		if (!in_slice) begin
			nxt_full  = 1'b0;
			nxt_last  = 1'b0;
			nxt_zeros = 2'd0;
			nxt_idx   = '0;
		end else if (!full_ff) begin
			if (mem_valid_i && req_ff) begin
				nxt_line = mem_data_i;
				nxt_full = 1'b1;
				nxt_last = mem_last_i;
				nxt_idx  = '0;
			end else if (last_ff) begin
				nxt_end = 1'b1; // Slice delimited
				nxt_last = 1'b0;
			end
		end else begin
			// Drop 0x03 after two zero bytes
			if (zeros_ff == 2'd2 && cur_byte == bsd_ctrl_pkg::EPB_BYTE) begin
				nxt_zeros = 2'd0;
			end else begin
				nxt_bvalid = 1'b1;
				nxt_bdata  = cur_byte;
				nxt_zeros  = (cur_byte == 8'h00) ? ((zeros_ff == 2'd2) ? 2'd2 : zeros_ff + 2'd1) : 2'd0;
			end
			nxt_idx = idx_ff + 7'd1;
			if (idx_ff == 7'h3f) begin
				nxt_full = 1'b0;
			end
		end
		// Prefetch while empty; drop on take so no line is lost
		nxt_req = in_slice && !nxt_full && !nxt_last && !nxt_end && !end_ff;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			line_ff   <= '0;
			idx_ff    <= '0;
			full_ff   <= 1'b0;
			last_ff   <= 1'b0;
			zeros_ff  <= 2'd0;
			bvalid_ff <= 1'b0;
			bdata_ff  <= 8'h00;
			end_ff    <= 1'b0;
			req_ff    <= 1'b0;
		end else begin
			line_ff   <= nxt_line;
			idx_ff    <= nxt_idx;
			full_ff   <= nxt_full;
			last_ff   <= nxt_last;
			zeros_ff  <= nxt_zeros;
			bvalid_ff <= nxt_bvalid;
			bdata_ff  <= nxt_bdata;
			end_ff    <= nxt_end;
			req_ff    <= nxt_req;
		end
	end

	// ---------------------------------------------------------------
	// Macroblock parameter fix-up
	// ---------------------------------------------------------------
	bsd_ctrl_pkg::mb_ctrl_t mb_ff, nxt_mb;
	logic [8:0]             pcm_cnt_ff, nxt_pcm_cnt;
	logic                   pcm_ff, nxt_pcm;

	always_comb begin
		nxt_mb      = mb_ff;
		nxt_pcm     = pcm_ff;
		nxt_pcm_cnt = pcm_cnt_ff;
		if (mb_valid_i) begin
			nxt_mb.non_skipped  = 1'b0;
			nxt_mb.cbp_luma     = mb_param_i.cbp_luma;
			nxt_mb.cbp_chroma   = mb_param_i.cbp_chroma;
			nxt_mb.dc_flags     = mb_param_i.dc_flags;
			nxt_mb.intra16_mode = mb_param_i.intra16_mode;
			nxt_mb.cb_present   = 1'b1;
			nxt_mb.cr_present   = 1'b1;
			if (mb_param_i.pcm) begin
				nxt_mb.non_skipped  = 1'b1;
				nxt_mb.cbp_luma     = '1;
				nxt_mb.cbp_chroma   = '1;
				nxt_mb.dc_flags     = 1'b0;
				nxt_mb.intra16_mode = '0;
				nxt_pcm             = 1'b1;
				nxt_pcm_cnt         = bsd_ctrl_pkg::PCM_BEATS;
			end
			if (mb_param_i.chroma_fmt == bsd_ctrl_pkg::CHROMA_MONO) begin
				nxt_mb.cbp_chroma = '0;
				nxt_mb.cb_present = 1'b0;
				nxt_mb.cr_present = 1'b0;
			end
		end else if (pcm_ff && mem_valid_i && req_ff) begin
			// Raw 384-byte sample payload, one line per beat
			nxt_pcm_cnt = pcm_cnt_ff - 9'd1;
			if (pcm_cnt_ff == 9'd1) begin
				nxt_pcm = 1'b0;
			end
		end
		if (!in_slice) begin
			nxt_pcm = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mb_ff      <= '0;
			pcm_ff     <= 1'b0;
			pcm_cnt_ff <= '0;
		end else begin
			mb_ff      <= nxt_mb;
			pcm_ff     <= nxt_pcm;
			pcm_cnt_ff <= nxt_pcm_cnt;
		end
	end

	// ---------------------------------------------------------------
	// Error status, counter and register reads
	// ---------------------------------------------------------------
	logic [bsd_ctrl_pkg::ERR_BITS-1:0] stat_ff, nxt_stat;
	logic [11:0]                       cnt_ff, nxt_cnt;
	logic [31:0]                       rdata_ff, nxt_rdata;
	logic                              ack_ff, nxt_ack;
	logic                              irq_ff, nxt_irq;
	logic [bsd_ctrl_pkg::ERR_BITS-1:0] gated;
	logic [2:0]                        n_err;

	assign gated = err_event_i & en_ff;

	always_comb begin
		nxt_stat = stat_ff;
		if (wr_status) begin
			nxt_stat = stat_ff & ~reg_wdata_i[bsd_ctrl_pkg::ERR_BITS-1:0];
		end
		nxt_stat = nxt_stat | gated; // Set wins over clear
		n_err = 3'd0;
		for (int i = 0; i < bsd_ctrl_pkg::ERR_BITS; i++) begin
			n_err = n_err + {2'b00, err_event_i[i]};
		end
		nxt_cnt = wr_count ? bsd_ctrl_pkg::RST_ERR_COUNT : cnt_ff;
		if ({1'b0, nxt_cnt} + {10'd0, n_err} > {1'b0, bsd_ctrl_pkg::CNT_MAX}) begin
			nxt_cnt = bsd_ctrl_pkg::CNT_MAX;
		end else begin
			nxt_cnt = nxt_cnt + {9'd0, n_err};
		end
		nxt_irq   = |nxt_stat;
		nxt_ack   = reg_rd_i | reg_wr_i;
		nxt_rdata = 32'h0000_0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				bsd_ctrl_pkg::ADDR_ERR_STATUS: nxt_rdata = {28'h0, stat_ff};
				bsd_ctrl_pkg::ADDR_ERR_COUNT:  nxt_rdata = {20'h0, cnt_ff};
				bsd_ctrl_pkg::ADDR_STREAMER:   nxt_rdata = {31'h0, slice_busy_o};
				bsd_ctrl_pkg::ADDR_FLUSH_CTL:  nxt_rdata = {31'h0, xflush_req_ff};
				default:                       nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			stat_ff  <= bsd_ctrl_pkg::RST_ERR_STATUS[bsd_ctrl_pkg::ERR_BITS-1:0];
			cnt_ff   <= bsd_ctrl_pkg::RST_ERR_COUNT;
			rdata_ff <= 32'h0000_0000;
			ack_ff   <= 1'b0;
			irq_ff   <= 1'b0;
		end else begin
			stat_ff  <= nxt_stat;
			cnt_ff   <= nxt_cnt;
			rdata_ff <= nxt_rdata;
			ack_ff   <= nxt_ack;
			irq_ff   <= nxt_irq;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o   = rdata_ff;
	assign reg_ack_o     = ack_ff;
	assign slice_busy_o  = busy_ff;
	assign slice_done_o  = done_ff;
	assign mem_req_o     = req_ff;
	assign byte_valid_o  = bvalid_ff;
	assign byte_data_o   = bdata_ff;
	assign slice_end_o   = end_ff;
	assign mb_ctrl_o     = mb_ff;
	assign pcm_active_o  = pcm_ff;
	assign flush_o       = flush_ff;
	assign store_dword_o = store_ff;
	assign irq_o         = irq_ff;
endmodule

/* File: bench/bsd_ctrl_properties.sv */
// Checker: port-level properties of the decoder control shell
`timescale 1ns/10ps
module bsd_ctrl_properties (
	input wire logic                    sys_clk_i,
	input wire logic                    srst_i,
	input wire logic                    reg_wr_i,
	input wire logic                    reg_rd_i,
	input wire logic [15:0]             reg_addr_i,
	input wire logic [31:0]             reg_rdata_o,
	input wire logic                    reg_ack_o,
	input wire logic                    slice_start_i,
	input wire logic                    slice_busy_o,
	input wire logic                    slice_done_o,
	input wire logic                    slice_end_o,
	input wire logic                    mem_req_o,
	input wire logic                    mb_valid_i,
	input wire bsd_ctrl_pkg::mb_param_t mb_param_i,
	input wire bsd_ctrl_pkg::mb_ctrl_t  mb_ctrl_o,
	input wire logic                    input_done_i,
	input wire logic                    parser_done_i,
	input wire logic                    memif_done_i,
	input wire logic                    flush_o,
	input wire logic                    store_dword_o,
	input wire logic                    irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	a_ack_timing: assert property (reg_ack_o == $past(reg_wr_i || reg_rd_i)) else $error("ack timing");
	a_status_rsv: assert property (reg_rd_i && reg_addr_i == bsd_ctrl_pkg::ADDR_ERR_STATUS
		|=> reg_ack_o && reg_rdata_o[31:4] == 28'h0) else $error("status reserved bits");
	a_count_rsv: assert property (reg_rd_i && reg_addr_i == bsd_ctrl_pkg::ADDR_ERR_COUNT
		|=> reg_rdata_o[31:12] == 20'h0) else $error("count reserved bits");
	a_irq_sticky: assert property (irq_o && !reg_wr_i && !$past(reg_wr_i) |=> irq_o) else $error("irq lost");
	a_start_fetch: assert property (slice_start_i && !slice_busy_o |=> slice_busy_o ##1 mem_req_o)
		else $error("slice start");
	a_busy_hold: assert property (slice_busy_o && !slice_done_o && !store_dword_o
		|=> slice_busy_o || slice_done_o || store_dword_o) else $error("busy dropped");
	a_end_flush: assert property (slice_end_o |-> ##[1:4] flush_o) else $error("no implicit flush");
	a_flush_waits: assert property (flush_o && !(input_done_i && parser_done_i && memif_done_i)
		|=> !slice_done_o && !store_dword_o) else $error("flush ended early");
	a_store_pulse: assert property (store_dword_o |=> !store_dword_o) else $error("store too long");
	a_pcm_ctrl: assert property (mb_valid_i && mb_param_i.pcm |=> mb_ctrl_o.non_skipped
		&& mb_ctrl_o.cbp_luma == 4'hf && !mb_ctrl_o.dc_flags) else $error("pcm control");
	a_mono_chroma: assert property (mb_valid_i && mb_param_i.chroma_fmt == bsd_ctrl_pkg::CHROMA_MONO
		|=> mb_ctrl_o.cbp_chroma == 2'h0 && !mb_ctrl_o.cb_present && !mb_ctrl_o.cr_present) else $error("mono");
	c_slice: cover property (slice_done_o);
	c_store: cover property (store_dword_o);
	c_irq: cover property ($rose(irq_o));
endmodule

/* File: bench/mem_model.sv */
// Partner: slice memory and unit done levels
`timescale 1ns/10ps
module mem_model (
	input  wire logic [0:0] sys_clk_i,
	input  wire logic       req_i,
	input  wire logic       flush_i,
	input  wire logic [3:0] slow_i,
	input  wire logic [1:0] lines_i,
	output logic            valid_o,
	output logic [511:0]    data_o,
	output logic            last_o,
	output logic            in_done_o,
	output logic            parse_done_o,
	output logic            memif_done_o
);
	logic [3:0]   wait_q, dly_q;
	logic [1:0]   line_q;
	logic [511:0] line;
	initial begin
		{valid_o, last_o, in_done_o, parse_done_o, memif_done_o} = 5'h0;
		{wait_q, dly_q, line_q} = 10'h0;
		data_o = '0;
		// Raw slice bytes with one escaped 00 00 03 00 00 run
		for (int k = 0; k < 64; k++) line[8*k+:8] = 8'(k + 1);
		line[80+:40] = 40'h0000030000;
	end
	always @(posedge sys_clk_i) begin
		valid_o <= 1'b0;
		last_o <= 1'b0;
		data_o <= ~data_o;
		if (req_i && !valid_o) begin
			if (wait_q == slow_i) begin
				valid_o <= 1'b1;
				data_o <= line;
				last_o <= (line_q + 2'h1 == lines_i);
				line_q <= (line_q + 2'h1 == lines_i) ? 2'h0 : line_q + 2'h1;
				wait_q <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
		// Units report done at staggered times during a flush
		dly_q <= (flush_i && dly_q != 4'hf) ? dly_q + 4'h1 : (flush_i ? dly_q : 4'h0);
		in_done_o <= flush_i;
		parse_done_o <= flush_i && dly_q >= slow_i;
		memif_done_o <= flush_i && dly_q > slow_i;
	end
endmodule

/* File: bench/tb_top.sv */
// Testbench: registers, slices, errors, flush and reset
`timescale 1ns/10ps
module tb_top;
	logic                    sys_clk_i, srst_i, reg_wr_i, reg_rd_i, slice_start_i, mb_valid_i;
	logic                    mem_valid_i, mem_last_i, mem_req_o, byte_valid_o, slice_end_o;
	logic                    input_done_i, parser_done_i, memif_done_i, flush_o, store_dword_o;
	logic                    irq_o, reg_ack_o, slice_busy_o, slice_done_o, pcm_active_o;
	logic [15:0]             reg_addr_i, hist;
	logic [31:0]             reg_wdata_i, reg_rdata_o, rd;
	logic [3:0]              err_enable_i, err_event_i, slow;
	logic [1:0]              lines;
	logic [511:0]            mem_data_i;
	logic [7:0]              byte_data_o;
	logic [11:0]             mbp [3] = '{12'h81d, 12'ha1d, 12'h1f8};
	logic [11:0]             mbm [3] = '{12'hffc, 12'hffc, 12'h0f0};
	logic [11:0]             mbe [3] = '{12'hf08, 12'hff8, 12'h000};
	bsd_ctrl_pkg::mb_param_t mb_param_i;
	bsd_ctrl_pkg::mb_ctrl_t  mb_ctrl_o;
	int                      n_fail, compares, nbytes, i;

	bsd_ctrl dut (.*);
	mem_model mem (.sys_clk_i(sys_clk_i), .req_i(mem_req_o), .flush_i(flush_o), .slow_i(slow),
		.lines_i(lines), .valid_o(mem_valid_i), .data_o(mem_data_i), .last_o(mem_last_i),
		.in_done_o(input_done_i), .parse_done_o(parser_done_i), .memif_done_o(memif_done_i));

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= wr;
		reg_rd_i <= !wr;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		#1 rd = reg_rdata_o;
		chk({31'h0, reg_ack_o}, 32'h1);
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic wait_hi(ref logic s);
		for (i = 0; i < 3000 && s !== 1'b1; i++) @(negedge sys_clk_i);
		chk({31'h0, s}, 32'h1);
	endtask
	task automatic run_slice(input logic [3:0] en, input logic [3:0] ev, input int nb);
		nbytes = 0;
		@(posedge sys_clk_i);
		slice_start_i <= 1'b1;
		err_enable_i <= en;
		@(posedge sys_clk_i);
		slice_start_i <= 1'b0;
		@(posedge sys_clk_i);
		slice_start_i <= 1'b1;
		err_event_i <= ev;
		@(posedge sys_clk_i);
		slice_start_i <= 1'b0;
		err_event_i <= 4'h0;
		rdchk(bsd_ctrl_pkg::ADDR_STREAMER, 32'h1);
		wait_hi(slice_done_o);
		repeat (4) @(posedge sys_clk_i);
		#1 chk({31'h0, slice_busy_o}, 32'h0);
		chk(nbytes, nb);
	endtask
	task automatic test_done;
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Byte stream watch: an escape byte after two zeros must be gone
	always @(posedge sys_clk_i) begin
		if (byte_valid_o) begin
			nbytes++;
			if (byte_data_o == 8'h03 && hist == 16'h0) chk(32'h3, 32'h0);
			hist = {hist[7:0], byte_data_o};
		end
	end
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		test_done;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{reg_wr_i, reg_rd_i, slice_start_i, mb_valid_i} = 4'h0;
		{reg_addr_i, reg_wdata_i, err_enable_i, err_event_i} = '0;
		mb_param_i = '0;
		hist = 16'hffff;
		lines = 2'h2;
		slow = 4'h0;
		srst_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rdchk(bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'h0);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_COUNT, 32'h0);
		acc(1'b1, 16'h4100, 32'hf);
		rdchk(16'h4100, 32'h0);
		run_slice(4'h5, 4'hf, 126);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'h5);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_COUNT, 32'h4);
		chk({31'h0, irq_o}, 32'h1);
		lines = 2'h1;
		slow = 4'h5;
		run_slice(4'h8, 4'h8, 63);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'hd);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_COUNT, 32'h5);
		acc(1'b1, bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'h4);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'h9);
		acc(1'b1, bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'hf);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'h0);
		repeat (2) @(posedge sys_clk_i);
		#1 chk({31'h0, irq_o}, 32'h0);
		acc(1'b1, bsd_ctrl_pkg::ADDR_ERR_COUNT, 32'h0);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_COUNT, 32'h0);
		@(posedge sys_clk_i);
		err_event_i <= 4'hf;
		repeat (1030) @(posedge sys_clk_i);
		err_event_i <= 4'h0;
		rdchk(bsd_ctrl_pkg::ADDR_ERR_COUNT, 32'hfff);
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk_i);
			mb_valid_i <= 1'b1;
			mb_param_i <= mbp[k];
			@(posedge sys_clk_i);
			mb_valid_i <= 1'b0;
			#1 chk({20'h0, mb_ctrl_o & mbm[k]}, {20'h0, mbe[k]});
		end
		chk({31'h0, pcm_active_o}, 32'h0);
		acc(1'b1, bsd_ctrl_pkg::ADDR_FLUSH_CTL, 32'h1);
		wait_hi(store_dword_o);
		@(posedge sys_clk_i);
		slice_start_i <= 1'b1;
		@(posedge sys_clk_i);
		slice_start_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		srst_i <= 1'b1;
		@(posedge sys_clk_i);
		srst_i <= 1'b0;
		#1 chk({28'h0, slice_busy_o, flush_o, mem_req_o, irq_o}, 32'h0);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_STATUS, 32'h0);
		rdchk(bsd_ctrl_pkg::ADDR_ERR_COUNT, 32'h0);
		test_done;
	end
endmodule

bind bsd_ctrl bsd_ctrl_properties chk_i (.*);
